// file: pkg/prt_cfg.svh
`ifndef PRT_CFG_SVH
`define PRT_CFG_SVH

// ************************************************************
// register map
// ************************************************************
`define PRT_ADDR_W        8
`define PRT_OFS_MODE      8'h00
`define PRT_OFS_STATUS    8'h04
`define PRT_OFS_VALUE     8'h08
`define PRT_OFS_SNAP      8'h0C
`define PRT_OFS_EVT       8'h10
`define PRT_OFS_EVT_MASK  8'h14

// ************************************************************
// field layout and reset values
// ************************************************************
`define PRT_DATA_W        32
`define PRT_CNT_W         20
`define PRT_OVF_W         12
`define PRT_LIMIT_LSB     0
`define PRT_TEN_BIT       24
`define PRT_IEN_BIT       25
`define PRT_FLAG_BIT      0
`define PRT_LIMIT_RST     20'hFFFFF
`define PRT_OVF_MAX       12'hFFF
`define PRT_OVF_ONE       12'h001
`define PRT_EVT_W         2
`define PRT_EVT_INTERVAL  0
`define PRT_EVT_OVF_WRAP  1

// ************************************************************
// prescaler
// ************************************************************
`define PRT_PRESCALE      16
`define PRT_PRE_W         4
`define PRT_PRE_LAST      4'hF

`endif

// file: pkg/prt_pkg.sv
`include "prt_cfg.svh"

package prt_pkg;

  typedef struct packed {
    logic [`PRT_ADDR_W-1:0] addr;
    logic [`PRT_DATA_W-1:0] wdata;
    logic                   wr;
    logic                   rd;
  } prt_bus_t;

  typedef struct packed {
    logic                  irq_en;
    logic                  tmr_en;
    logic [`PRT_CNT_W-1:0] limit;
  } prt_mode_t;

  typedef struct packed {
    logic [`PRT_OVF_W-1:0] ovf;
    logic [`PRT_CNT_W-1:0] cnt;
  } prt_count_t;

  typedef enum logic [1:0] {
    PRT_ST_IDLE = 2'b01,
    PRT_ST_RUN  = 2'b10
  } prt_run_t;

endpackage : prt_pkg

// file: verilog/prt_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
`include "prt_cfg.svh"

// ************************************************************
// divide-by-16 tick source, frozen while held
// ************************************************************
module prt_prescaler (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic hold,
  output logic      tick
);

  logic [`PRT_PRE_W-1:0] div_cnt;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_cnt <= '0;
    end else if (!hold) begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick <= 1'b0;
    end else begin
      tick <= !hold && (div_cnt == `PRT_PRE_LAST);
    end
  end

  a_tick_spacing : assert property (@(posedge sys_clk) disable iff (rst) // see RULE2
    tick |=> (!tick) [*8] ##1 (!tick) [*7])
    else $error("prescaler tick closer than sixteen cycles");

endmodule : prt_prescaler

`default_nettype wire

// file: verilog/prt_interval_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "prt_cfg.svh"

// What this block does
// RULE1: count up, wrap at limit, bump overflow
// RULE2: primary counter advances once per sixteen clocks
// RULE3: wrap sets flag; irq when flag and enabled
// RULE4: writing limit never restarts the counters
// RULE5: value read returns counts, clears overflow, flag
// RULE6: snapshot read returns counts, changes nothing
// RULE7: starts disabled; enable acts at zero count
// RULE8: disabled timer finishes interval, then holds zero
// RULE9: debug halt freezes both counters
// RULE10: interval lasts limit plus one ticks
// RULE11: mode: limit 19:0, enable 24, irq 25
// RULE12: counts: primary 19:0, overflow 31:20
// RULE13: overflow counts intervals since last value read
// RULE14: status bit 0 is flag, rest zero
// RULE15: mode 0x00, status 0x04, value 0x08, snapshot 0x0C
// RULE16: overflow wraps; read-only writes ignored
module prt_interval_timer (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire prt_pkg::prt_bus_t bus_req,
  output logic [`PRT_DATA_W-1:0] bus_rdata,
  input  wire logic              debug_halt,
  output logic                   irq
);

  // ************************************************************
  // state
  // ************************************************************
  prt_pkg::prt_mode_t              mode;
  prt_pkg::prt_run_t               run_state;
  logic [`PRT_CNT_W-1:0]           primary_count;
  logic [`PRT_OVF_W-1:0]           interval_overflow_count;
  logic                            interval_reached_flag;
  logic [`PRT_EVT_W-1:0]           evt_status;
  logic [`PRT_EVT_W-1:0]           evt_mask;
  logic [`PRT_EVT_W-1:0]           evt_hit;
  prt_pkg::prt_count_t             count_view;
  logic [`PRT_DATA_W-1:0]          next_rdata;
  logic                            next_irq;
  logic                            tick;
  logic                            step;
  logic                            wrap;
  logic                            wr_mode;
  logic                            wr_mask;
  logic                            rd_status;
  logic                            rd_value;
  logic                            rd_snap;
  logic                            rd_evt;

  // ************************************************************
  // prescaler
  // ************************************************************
  prt_prescaler u_prescaler (
    .sys_clk (sys_clk),
    .rst     (rst),
    .hold    (debug_halt), // see RULE9
    .tick    (tick)
  );

  // ************************************************************
  // address decode
  // ************************************************************
  // only mode and mask accept writes
  assign wr_mode   = bus_req.wr && (bus_req.addr == `PRT_OFS_MODE); // see RULE15
  assign wr_mask   = bus_req.wr && (bus_req.addr == `PRT_OFS_EVT_MASK); // see RULE16
  assign rd_status = bus_req.rd && (bus_req.addr == `PRT_OFS_STATUS);
  assign rd_value  = bus_req.rd && (bus_req.addr == `PRT_OFS_VALUE); // see RULE15
  assign rd_snap   = bus_req.rd && (bus_req.addr == `PRT_OFS_SNAP);
  assign rd_evt    = bus_req.rd && (bus_req.addr == `PRT_OFS_EVT);

  // ************************************************************
  // counting qualifiers
  // ************************************************************
  // one step per prescaled tick, none under debug halt
  assign step = tick && !debug_halt && (run_state == prt_pkg::PRT_ST_RUN); // see RULE2
  // full-width compare, so an interval is limit+1 steps
  assign wrap = step && (primary_count == mode.limit); // see RULE10

  // ************************************************************
  // mode register
  // ************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode.limit  <= `PRT_LIMIT_RST; // see RULE11
      mode.tmr_en <= 1'b0; // see RULE7
      mode.irq_en <= 1'b0;
    end else if (wr_mode) begin
      // counters are not touched here
      mode.limit  <= bus_req.wdata[`PRT_LIMIT_LSB +: `PRT_CNT_W]; // see RULE4
      mode.tmr_en <= bus_req.wdata[`PRT_TEN_BIT]; // see RULE11
      mode.irq_en <= bus_req.wdata[`PRT_IEN_BIT]; // see RULE11
    end
  end

  // ************************************************************
  // run control
  // ************************************************************
  // idle only with primary count at zero, so enable acts at zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      run_state <= prt_pkg::PRT_ST_IDLE; // see RULE7
    end else begin
      case (run_state)
        prt_pkg::PRT_ST_IDLE: begin
          if (mode.tmr_en) begin
            run_state <= prt_pkg::PRT_ST_RUN; // see RULE7
          end
        end
        prt_pkg::PRT_ST_RUN: begin
          // a cleared enable still lets the interval finish
          if (wrap && !mode.tmr_en) begin
            run_state <= prt_pkg::PRT_ST_IDLE; // see RULE8
          end
        end
        default: begin
          run_state <= prt_pkg::PRT_ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // primary counter
  // ************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      primary_count <= '0;
    end else if (wrap) begin
      primary_count <= '0; // see RULE1
    end else if (step) begin
      primary_count <= primary_count + 1'b1; // see RULE1
    end
  end

  // ************************************************************
  // interval overflow counter
  // ************************************************************
  // a wrap in the clearing-read cycle is kept as the first interval
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      interval_overflow_count <= '0;
    end else if (wrap && rd_value) begin
      interval_overflow_count <= `PRT_OVF_ONE; // see RULE13
    end else if (wrap) begin
      // natural modulo wrap at the maximum
      interval_overflow_count <= interval_overflow_count + 1'b1; // see RULE16
    end else if (rd_value) begin
      interval_overflow_count <= '0; // see RULE5
    end
  end

  // ************************************************************
  // interval reached flag
  // ************************************************************
  // set wins over the clearing read
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      interval_reached_flag <= 1'b0;
    end else if (wrap) begin
      interval_reached_flag <= 1'b1; // see RULE3
    end else if (rd_value) begin
      interval_reached_flag <= 1'b0; // see RULE5
    end
  end

  // ************************************************************
  // event status and mask
  // ************************************************************
  assign evt_hit[`PRT_EVT_INTERVAL] = wrap;
  assign evt_hit[`PRT_EVT_OVF_WRAP] = wrap && (interval_overflow_count == `PRT_OVF_MAX);

  generate
    for (genvar i = 0; i < `PRT_EVT_W; i++) begin : g_evt
      // set wins over read-to-clear
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          evt_status[i] <= 1'b0;
        end else if (evt_hit[i]) begin
          evt_status[i] <= 1'b1;
        end else if (rd_evt) begin
          evt_status[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      evt_mask <= '0;
    end else if (wr_mask) begin
      evt_mask <= bus_req.wdata[`PRT_EVT_W-1:0];
    end
  end

  // ************************************************************
  // interrupt
  // ************************************************************
  always_comb begin
    next_irq = (interval_reached_flag && mode.irq_en) || (|(evt_status & evt_mask)); // see RULE3
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  // ************************************************************
  // read data
  // ************************************************************
  assign count_view.ovf = interval_overflow_count; // see RULE12
  assign count_view.cnt = primary_count; // see RULE12

  always_comb begin
    next_rdata = '0;
    case (bus_req.addr)
      `PRT_OFS_MODE: begin
        next_rdata[`PRT_LIMIT_LSB +: `PRT_CNT_W] = mode.limit;
        next_rdata[`PRT_TEN_BIT]                 = mode.tmr_en;
        next_rdata[`PRT_IEN_BIT]                 = mode.irq_en;
      end
      `PRT_OFS_STATUS: begin
        next_rdata[`PRT_FLAG_BIT] = interval_reached_flag; // see RULE14
      end
      `PRT_OFS_VALUE: begin
        next_rdata = count_view; // see RULE5
      end
      `PRT_OFS_SNAP: begin
        next_rdata = count_view; // see RULE6
      end
      `PRT_OFS_EVT: begin
        next_rdata[`PRT_EVT_W-1:0] = evt_status;
      end
      `PRT_OFS_EVT_MASK: begin
        next_rdata[`PRT_EVT_W-1:0] = evt_mask;
      end
      default: begin
        next_rdata = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus_rdata <= '0;
    end else if (bus_req.rd) begin
      bus_rdata <= next_rdata;
    end else begin
      bus_rdata <= '0;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  a_wrap_to_zero : assert property (@(posedge sys_clk) disable iff (rst) // see RULE1
    wrap |=> (primary_count == '0))
    else $error("primary count did not return to zero after wrap");

  a_ovf_increment : assert property (@(posedge sys_clk) disable iff (rst) // see RULE13
    (wrap && !rd_value) |=>
      (interval_overflow_count == $past(interval_overflow_count) + 1'b1))
    else $error("overflow count did not step on wrap");

  a_flag_on_wrap : assert property (@(posedge sys_clk) disable iff (rst) // see RULE3
    wrap |=> interval_reached_flag)
    else $error("flag not set after wrap");

  a_irq_follows_flag : assert property (@(posedge sys_clk) disable iff (rst) // see RULE3
    (interval_reached_flag && mode.irq_en) |=> irq)
    else $error("irq low while enabled flag set");

  a_limit_write_keeps : assert property (@(posedge sys_clk) disable iff (rst) // see RULE4
    (wr_mode && !step) |=> $stable(primary_count) && $stable(interval_overflow_count))
    else $error("mode write disturbed the counters");

  a_value_read_clears : assert property (@(posedge sys_clk) disable iff (rst) // see RULE5
    (rd_value && !wrap) |=> (interval_overflow_count == '0) && !interval_reached_flag)
    else $error("clearing read did not clear overflow and flag");

  a_snap_read_keeps : assert property (@(posedge sys_clk) disable iff (rst) // see RULE6
    (rd_snap && !step) |=> $stable(interval_overflow_count) && $stable(interval_reached_flag)
      && (bus_rdata == {$past(interval_overflow_count), $past(primary_count)}))
    else $error("snapshot read wrong or had a side effect");

  a_idle_at_zero : assert property (@(posedge sys_clk) disable iff (rst) // see RULE8
    (run_state == prt_pkg::PRT_ST_IDLE) |-> (primary_count == '0))
    else $error("idle timer holds a nonzero count");

  a_halt_freezes : assert property (@(posedge sys_clk) disable iff (rst) // see RULE9
    debug_halt |=> $stable(primary_count) && $stable(interval_overflow_count))
    else $error("counters moved under debug halt");

  a_status_layout : assert property (@(posedge sys_clk) disable iff (rst) // see RULE14
    rd_status |=> (bus_rdata == {{(`PRT_DATA_W-1){1'b0}}, $past(interval_reached_flag)}))
    else $error("status read layout wrong");

  a_enable_at_zero : assert property (@(posedge sys_clk) disable iff (rst) // see RULE7
    $changed(run_state) |-> (primary_count == '0))
    else $error("run state changed away from zero count");

  a_count_only_on_step : assert property (@(posedge sys_clk) disable iff (rst) // see RULE2
    !step |=> $stable(primary_count))
    else $error("primary count moved without a prescaled tick");

  a_count_increment : assert property (@(posedge sys_clk) disable iff (rst) // see RULE10
    (step && (primary_count != mode.limit)) |=>
      (primary_count == $past(primary_count) + 1'b1))
    else $error("primary count did not step by one below the limit");

  a_flag_holds : assert property (@(posedge sys_clk) disable iff (rst) // see RULE14
    (!wrap && !rd_value) |=> $stable(interval_reached_flag))
    else $error("flag changed without wrap or clearing read");

  a_irq_off_masked : assert property (@(posedge sys_clk) disable iff (rst) // see RULE3
    (!(interval_reached_flag && mode.irq_en) && ((evt_status & evt_mask) == '0)) |=> !irq)
    else $error("irq high with no enabled source");

  a_ro_write_ignored : assert property (@(posedge sys_clk) disable iff (rst) // see RULE16
    (bus_req.wr && (bus_req.addr != `PRT_OFS_MODE)) |=> $stable(mode))
    else $error("write to another offset changed the mode register");

  a_rdata_idle : assert property (@(posedge sys_clk) disable iff (rst) // see RULE15
    !bus_req.rd |=> (bus_rdata == '0))
    else $error("read data not zero outside a read");

  a_unmapped_read_zero : assert property (@(posedge sys_clk) disable iff (rst) // see RULE15
    (bus_req.rd && (bus_req.addr > `PRT_OFS_EVT_MASK)) |=> (bus_rdata == '0))
    else $error("unmapped read returned nonzero data");

  a_value_read_data : assert property (@(posedge sys_clk) disable iff (rst) // see RULE5
    rd_value |=>
      (bus_rdata == {$past(interval_overflow_count), $past(primary_count)}))
    else $error("clearing read returned wrong counts");

  a_mode_write_lands : assert property (@(posedge sys_clk) disable iff (rst) // see RULE11
    wr_mode |=> (mode.limit == $past(bus_req.wdata[`PRT_LIMIT_LSB +: `PRT_CNT_W]))
      && (mode.irq_en == $past(bus_req.wdata[`PRT_IEN_BIT])))
    else $error("mode write did not land");

endmodule : prt_interval_timer

`default_nettype wire

// file: tb/test_periodic_interval_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "prt_cfg.svh"

module test_periodic_interval_timer;

  logic              sys_clk    = 1'b0;
  logic              rst        = 1'b1;
  logic              debug_halt = 1'b0;
  prt_pkg::prt_bus_t bus_req    = '0;
  logic [31:0]       bus_rdata;
  logic              irq;
  int                cyc        = 0;
  int                failures   = 0;
  int                n_tests    = 0;
  int                t;
  int                t2;
  logic [31:0]       junk;

  prt_interval_timer i_dut (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .bus_req    (bus_req),
    .bus_rdata  (bus_rdata),
    .debug_halt (debug_halt),
    .irq        (irq)
  );

  always #5 sys_clk = ~sys_clk;

  always @(posedge sys_clk) cyc <= cyc + 1;

  // ************************************************************
  // checking and closing
  // ************************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic final_report;
    $display("checks=%0d failures=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  // cycle ceiling well above the longest run
  always @(posedge sys_clk) begin
    if (cyc == 70000) begin
      failures++;
      final_report();
    end
  end

  // ************************************************************
  // register access
  // ************************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    #1;
    d = bus_rdata;
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    check(d, exp);
  endtask : rc

  task automatic wait_to(input int n);
    while (cyc < n) begin
      @(posedge sys_clk);
      #1;
    end
  endtask : wait_to

  task automatic wait_irq(output int ts);
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 300) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    if (k == 300) begin
      failures++;
    end
    ts = cyc;
  endtask : wait_irq

  task automatic irq_is(input logic exp);
    repeat (2) @(posedge sys_clk);
    #1;
    check({31'h0, irq}, {31'h0, exp});
  endtask : irq_is

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    check({31'h0, irq}, 32'h0);
    rc(`PRT_OFS_MODE, 32'h000F_FFFF);
    rc(`PRT_OFS_STATUS, 32'h0);
    rc(`PRT_OFS_VALUE, 32'h0);
    rc(`PRT_OFS_SNAP, 32'h0);
    // read-only places keep their contents
    wr(`PRT_OFS_STATUS, 32'hFFFF_FFFF);
    wr(`PRT_OFS_VALUE, 32'hFFFF_FFFF);
    wr(`PRT_OFS_SNAP, 32'hFFFF_FFFF);
    rc(`PRT_OFS_STATUS, 32'h0);
    rc(`PRT_OFS_SNAP, 32'h0);
    rc(8'h40, 32'h0);
    // limit 3, timer and irq enabled
    wr(`PRT_OFS_MODE, 32'h0300_0003);
    rc(`PRT_OFS_MODE, 32'h0300_0003);
    wait_irq(t);
    rc(`PRT_OFS_SNAP, 32'h0010_0000);
    rc(`PRT_OFS_STATUS, 32'h1);
    rc(`PRT_OFS_SNAP, 32'h0010_0000);
    rc(`PRT_OFS_VALUE, 32'h0010_0000);
    rc(`PRT_OFS_STATUS, 32'h0);
    check({31'h0, irq}, 32'h0);
    // three whole intervals of 64 cycles
    wait_to(t + 190);
    rc(`PRT_OFS_SNAP, 32'h0030_0000);
    rc(`PRT_OFS_VALUE, 32'h0030_0000);
    // new limit mid-interval leaves the count alone
    wait_to(t + 212);
    rc(`PRT_OFS_SNAP, 32'h0000_0001);
    wr(`PRT_OFS_MODE, 32'h0300_0005);
    rc(`PRT_OFS_SNAP, 32'h0000_0001);
    wait_irq(t2);
    check(32'(t2 - t), 32'd288);
    // disable mid-interval: finish, then hold at zero
    wait_to(t2 + 20);
    wr(`PRT_OFS_MODE, 32'h0200_0005);
    wait_to(t2 + 200);
    rc(`PRT_OFS_SNAP, 32'h0020_0000);
    wait_to(t2 + 300);
    rc(`PRT_OFS_SNAP, 32'h0020_0000);
    check({31'h0, irq}, 32'h1);
    rc(`PRT_OFS_VALUE, 32'h0020_0000);
    irq_is(1'b0);
    wr(`PRT_OFS_MODE, 32'h0300_0005);
    wait_irq(t);
    rc(`PRT_OFS_SNAP, 32'h0010_0000);
    // debug halt freezes counting
    wait_to(t + 20);
    @(posedge sys_clk);
    debug_halt <= 1'b1;
    repeat (100) @(posedge sys_clk);
    rc(`PRT_OFS_SNAP, 32'h0010_0001);
    debug_halt <= 1'b0;
    rc(`PRT_OFS_VALUE, 32'h0010_0001);
    irq_is(1'b0);
    wait_irq(t);
    // limit 0 at zero count, irq enable off
    wr(`PRT_OFS_MODE, 32'h0100_0000);
    irq_is(1'b0);
    rc(`PRT_OFS_EVT, 32'h1);
    wr(`PRT_OFS_EVT_MASK, 32'h1);
    repeat (20) @(posedge sys_clk);
    irq_is(1'b1);
    wr(`PRT_OFS_EVT_MASK, 32'h0);
    irq_is(1'b0);
    // 4096 intervals wrap the overflow count
    wait_to(t + 40);
    rd(`PRT_OFS_VALUE, junk);
    wait_to(t + 40 + 65536);
    rc(`PRT_OFS_SNAP, 32'h0);
    rc(`PRT_OFS_EVT, 32'h3);
    final_report();
  end

endmodule : test_periodic_interval_timer

`default_nettype wire
